// File: rtl/synth_serial_register_load.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Configuration load stores only configuration register
// - A load also moves 13 reference bits
// - A load keeps reference buffer, configuration
// - Reference upper three bits apply at once
// - Reference low bits only to first buffer
// - Extra strobe moves first buffer to second
// - Counter finishes present cycle before new ratio
// - Feedback ratio is main times 64 plus swallow
// - Open-drain output B under register control
module synth_serial_register_load
  import synth_load_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Serial port pins from the host
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic load_strobe_n_i,
  // Cascade control
  input wire logic chain_en_i,
  input wire logic [1:0] chain_len_i,
  output logic sdata_o,
  // Counter input pins
  input wire logic reference_input_i,
  input wire logic vco_i,
  // Register contents
  output logic [CFG_W-1:0] cfg_o,
  output logic [A_W-1:0] swallow_o,
  output logic [N_W-1:0] main_o,
  output logic [REF_LOW_W-1:0] ref_first_o,
  output logic [REF_LOW_W-1:0] ref_second_o,
  output logic [REF_FUNC_W-1:0] ref_func_o,
  output logic ref_pending_o,
  // Divided outputs
  output logic phase_compare_frequency_o,
  output logic vco_div_o,
  // Open-drain output B
  output logic out_b_o,
  output logic out_b_oe_n_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] sync_first;
  logic [PIN_COUNT-1:0] sync_second;
  logic [PIN_COUNT-1:0] pins_prev;

  assign pins = {vco_i, reference_input_i, load_strobe_n_i, sdata_i, sclk_i};

  // Two flip-flops per pin, then one more to find edges
  // Reset to each pin's idle level, so no false strobe edge follows reset
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sync_first[gi] <= (gi == PIN_STROBE_N);
          sync_second[gi] <= (gi == PIN_STROBE_N);
          pins_prev[gi] <= (gi == PIN_STROBE_N);
        end else begin
          sync_first[gi] <= pins[gi];
          sync_second[gi] <= sync_first[gi];
          pins_prev[gi] <= sync_second[gi];
        end
      end
    end
  endgenerate

  logic sclk_rise;
  logic strobe_low;
  logic strobe_rise;
  logic ref_tick;
  logic vco_tick;

  // Edge events and the strobe level on the synchronised pins
  assign sclk_rise = sync_second[PIN_SCLK] & ~pins_prev[PIN_SCLK];
  assign strobe_low = ~sync_second[PIN_STROBE_N];
  assign strobe_rise = sync_second[PIN_STROBE_N] & ~pins_prev[PIN_STROBE_N];
  assign ref_tick = sync_second[PIN_REF] & ~pins_prev[PIN_REF];
  assign vco_tick = sync_second[PIN_VCO] & ~pins_prev[PIN_VCO];

  // ****************************************************************
  // Serial shifter
  // ****************************************************************
  logic [SHIFT_W-1:0] shifter;
  logic [SHIFT_W-1:0] next_shifter;
  logic [CNT_W-1:0] bit_count;
  logic [CNT_W-1:0] next_bit_count;
  logic next_sdata;
  logic leaving_bit;

  // Bit that reaches the top of this device's window with this shift,
  // so the next device samples it on the following serial clock
  always_comb begin
    case (chain_len_i)
      LEN_CFG: leaving_bit = shifter[BITS_CFG-2];
      LEN_REF: leaving_bit = shifter[BITS_REF-2];
      default: leaving_bit = shifter[BITS_AB-2];
    endcase
  end

  // Shift while the strobe is low; count restarts when it is high
  always_comb begin
    next_shifter = shifter;
    next_bit_count = bit_count;
    next_sdata = sdata_o;
    if (!strobe_low) begin
      next_bit_count = '0;
    end else if (sclk_rise) begin
      next_shifter = {shifter[SHIFT_W-2:0], sync_second[PIN_SDATA]};
      if (bit_count != CNT_MAX) begin
        next_bit_count = bit_count + CNT_W'(1);
      end
      next_sdata = leaving_bit;
    end
    // Cascade output quiet as soon as the cascade is off
    if (!chain_en_i) begin
      next_sdata = 1'b0;
    end
  end

  // Shifter registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shifter <= '0;
      bit_count <= '0;
      sdata_o <= 1'b0;
    end else begin
      shifter <= next_shifter;
      bit_count <= next_bit_count;
      sdata_o <= next_sdata;
    end
  end

  // ****************************************************************
  // Register commit on strobe release
  // ****************************************************************
  logic [CNT_W-1:0] own_bits;
  logic [CFG_W-1:0] next_cfg;
  logic [A_W-1:0] next_swallow;
  logic [N_W-1:0] next_main;
  logic [REF_LOW_W-1:0] next_ref_first;
  logic [REF_LOW_W-1:0] next_ref_second;
  logic [REF_FUNC_W-1:0] next_ref_func;
  logic next_ref_pending;

  // In a cascade each device owns half of the bits
  assign own_bits = chain_en_i ? (bit_count >> 1) : bit_count;

  // Frame length selects the register that is loaded
  always_comb begin
    next_cfg = cfg_o;
    next_swallow = swallow_o;
    next_main = main_o;
    next_ref_first = ref_first_o;
    next_ref_second = ref_second_o;
    next_ref_func = ref_func_o;
    next_ref_pending = ref_pending_o;
    if (strobe_rise) begin
      case (own_bits)
        BITS_CFG: begin
          next_cfg = shifter[CFG_W-1:0];
        end
        BITS_REF: begin
          next_ref_func = shifter[REF_FUNC_LSB +: REF_FUNC_W];
          next_ref_first = shifter[REF_LOW_W-1:0];
          next_ref_pending = 1'b1;
        end
        BITS_AB: begin
          next_swallow = shifter[A_LSB +: A_W];
          next_main = shifter[N_LSB +: N_W];
          next_ref_second = ref_first_o;
          next_ref_pending = 1'b0;
        end
        BITS_NONE: begin
          if (ref_pending_o) begin
            next_ref_second = ref_first_o;
            next_ref_pending = 1'b0;
          end
        end
        default: begin
          next_ref_pending = ref_pending_o;
        end
      endcase
    end
  end

  // Register file
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_o <= CFG_RST;
      swallow_o <= A_RST;
      main_o <= N_RST;
      ref_first_o <= REF_LOW_RST;
      ref_second_o <= REF_LOW_RST;
      ref_func_o <= REF_FUNC_RST;
      ref_pending_o <= 1'b0;
    end else begin
      cfg_o <= next_cfg;
      swallow_o <= next_swallow;
      main_o <= next_main;
      ref_first_o <= next_ref_first;
      ref_second_o <= next_ref_second;
      ref_func_o <= next_ref_func;
      ref_pending_o <= next_ref_pending;
    end
  end

  // ****************************************************************
  // Open-drain output B
  // ****************************************************************
  logic next_out_b_oe_n;

  assign next_out_b_oe_n = cfg_o[CFG_OUT_B_BIT];

  // Pin driver registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_b_o <= 1'b0;
      out_b_oe_n_o <= 1'b1;
    end else begin
      out_b_o <= 1'b0;
      out_b_oe_n_o <= next_out_b_oe_n;
    end
  end

  // ****************************************************************
  // Reference and feedback dividers
  // ****************************************************************
  logic [TOTAL_W-1:0] total_ratio;

  assign total_ratio = (TOTAL_W'(main_o) << PRESCALE_SHIFT) + TOTAL_W'(swallow_o);

  ratio_divider #(
    .WIDTH(REF_LOW_W)
  ) u_ref_div (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tick_i(ref_tick),
    .ratio_i(ref_second_o),
    .pulse_o(phase_compare_frequency_o)
  );

  // Feedback counter
  ratio_divider #(
    .WIDTH(TOTAL_W)
  ) u_vco_div (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tick_i(vco_tick),
    .ratio_i(total_ratio),
    .pulse_o(vco_div_o)
  );

endmodule
`default_nettype wire

// File: shared/synth_load_pkg.sv
// ****************************************************************
// Constants of the serial register load block
// ****************************************************************
package synth_load_pkg;

  // Pin synchroniser layout
  localparam int SYNC_STAGES = 2;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_STROBE_N = 2;
  localparam int PIN_REF = 3;
  localparam int PIN_VCO = 4;
  localparam int PIN_COUNT = 5;

  // Shifter and frame lengths in bits per device
  localparam int SHIFT_W = 24;
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_MAX = 6'h30;
  localparam logic [5:0] BITS_NONE = 6'h00;
  localparam logic [5:0] BITS_CFG = 6'h08;
  localparam logic [5:0] BITS_REF = 6'h10;
  localparam logic [5:0] BITS_AB = 6'h18;

  // Cascade length select codes
  localparam logic [1:0] LEN_CFG = 2'h0;
  localparam logic [1:0] LEN_REF = 2'h1;

  // Configuration register fields
  localparam int CFG_W = 8;
  localparam int CFG_OUT_B_BIT = 0;
  localparam logic [7:0] CFG_RST = 8'h00;

  // Reference register fields
  localparam int REF_LOW_W = 13;
  localparam int REF_FUNC_LSB = 13;
  localparam int REF_FUNC_W = 3;
  localparam logic [12:0] REF_LOW_RST = 13'h0000;
  localparam logic [2:0] REF_FUNC_RST = 3'h0;

  // A register fields: swallow count low, main count above
  localparam int A_LSB = 0;
  localparam int A_W = 6;
  localparam int N_LSB = 6;
  localparam int N_W = 12;
  localparam logic [5:0] A_RST = 6'h00;
  localparam logic [11:0] N_RST = 12'h000;

  // Feedback ratio = main * 64 + swallow
  localparam int PRESCALE_SHIFT = 6;
  localparam int TOTAL_W = 18;

endpackage

// File: rtl/ratio_divider.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Programmable divider that reloads only at its terminal count
// ****************************************************************
module ratio_divider #(
  parameter int WIDTH = 13
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Input events and ratio
  input wire logic tick_i,
  input wire logic [WIDTH-1:0] ratio_i,
  // Divided output
  output logic pulse_o
);

  // Width check at elaboration
  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("ratio_divider: WIDTH out of range");
  end

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_pulse;

  // Count down; the new ratio is taken only after the present cycle
  // reload at terminal count
  always_comb begin
    next_count = count;
    next_pulse = 1'b0;
    if (tick_i) begin
      if (count <= WIDTH'(1)) begin
        next_count = ratio_i;
        next_pulse = 1'b1;
      end else begin
        next_count = count - WIDTH'(1);
      end
    end
  end

  // State registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= '0;
      pulse_o <= 1'b0;
    end else begin
      count <= next_count;
      pulse_o <= next_pulse;
    end
  end

endmodule
`default_nettype wire

// File: verif/serial_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Host serial port driving clock, data and load strobe
// ****************************************************************
module serial_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Serial pins
  output logic sclk_o,
  output logic sdata_o,
  output logic load_strobe_n_o
);
  // Idle levels at time zero
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    load_strobe_n_o = 1'b1;
  end

  // Wait whole cycles, then step just past the edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // Frame of n bits, most significant first; n of 0 is an empty strobe
  task automatic send(input logic [23:0] v, input int n);
    load_strobe_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdata_o = v[i];
      wait_cyc(4);
      sclk_o = 1'b1;
      wait_cyc(4);
      sclk_o = 1'b0;
    end
    wait_cyc(4);
    load_strobe_n_o = 1'b1;
    sdata_o = ~sdata_o; // Released line does not keep its last value
    wait_cyc(8);
  endtask
endmodule
`default_nettype wire

// File: verif/synth_serial_register_load_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Checker on the register load ports
// ****************************************************************
module load_checker
  import synth_load_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Pins
  input wire logic sclk_i,
  input wire logic load_strobe_n_i,
  input wire logic chain_en_i,
  input wire logic sdata_o,
  // Registers
  input wire logic [CFG_W-1:0] cfg_o,
  input wire logic [A_W-1:0] swallow_o,
  input wire logic [N_W-1:0] main_o,
  input wire logic [REF_LOW_W-1:0] ref_first_o,
  input wire logic [REF_LOW_W-1:0] ref_second_o,
  input wire logic [REF_FUNC_W-1:0] ref_func_o,
  input wire logic ref_pending_o,
  // Outputs
  input wire logic phase_compare_frequency_o,
  input wire logic vco_div_o,
  input wire logic out_b_o,
  input wire logic out_b_oe_n_o
);
  logic [5:0] bit_cnt, next_bit_cnt, last_bits, next_last_bits;
  logic sclk_q, strobe_q;
  logic [5:0] own_last;

  // In a cascade each device owns half of the frame
  assign own_last = chain_en_i ? (last_bits >> 1) : last_bits;

  // Count bits of a frame and keep the length at strobe rise
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_last_bits = last_bits;
    if (load_strobe_n_i) next_bit_cnt = 6'h00;
    else if (sclk_i && !sclk_q) next_bit_cnt = bit_cnt + 6'h01;
    if (load_strobe_n_i && !strobe_q) next_last_bits = bit_cnt;
  end

  // Register the frame counters
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) {bit_cnt, last_bits, sclk_q, strobe_q} <= {6'h00, 6'h00, 1'b0, 1'b1};
    else {bit_cnt, last_bits, sclk_q, strobe_q} <= {next_bit_cnt, next_last_bits, sclk_i, load_strobe_n_i};
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_cfg_on_byte: assert property ($changed(cfg_o) |-> own_last == BITS_CFG)
    else $error("cfg changed outside a byte load");
  a_ab_on_long: assert property (($changed(swallow_o) || $changed(main_o)) |-> own_last == BITS_AB)
    else $error("swallow or main changed outside a long load");
  a_first_on_ref: assert property (($changed(ref_first_o) || $changed(ref_func_o)) |-> own_last == BITS_REF)
    else $error("reference fields changed outside a reference load");
  a_second_copy: assert property ($changed(ref_second_o) |-> ref_second_o == ref_first_o && own_last != BITS_REF)
    else $error("second buffer not copied from first");
  a_pending_set: assert property ($rose(ref_pending_o) |-> own_last == BITS_REF)
    else $error("pending set without reference load");
  a_pending_clear: assert property ($fell(ref_pending_o) |-> own_last == BITS_NONE || own_last == BITS_AB)
    else $error("pending cleared by wrong frame");
  a_out_b_follow: assert property ($past(rstn_i) |-> out_b_oe_n_o == $past(cfg_o[CFG_OUT_B_BIT]) && !out_b_o)
    else $error("output B enable not following cfg bit");
  a_ref_pulse_one: assert property (phase_compare_frequency_o |=> !phase_compare_frequency_o)
    else $error("reference pulse longer than a cycle");
  a_vco_pulse_one: assert property (vco_div_o |=> !vco_div_o)
    else $error("feedback pulse longer than a cycle");
  a_chain_quiet: assert property (!chain_en_i ##1 !chain_en_i |-> !sdata_o)
    else $error("cascade out active while off");

  c_cfg: cover property ($changed(cfg_o));
  c_copy: cover property ($changed(ref_second_o));
  c_pend: cover property ($rose(ref_pending_o));
endmodule
bind synth_serial_register_load load_checker u_load_checker (.*);
`default_nettype wire

// File: verif/synth_serial_register_load_bench.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Bench for the serial register load block
// ****************************************************************
module synth_serial_register_load_bench
  import synth_load_pkg::*;
;
  logic sys_clk_i, rstn_i, sclk_i, sdata_i, load_strobe_n_i, chain_en_i, reference_input_i, vco_i;
  logic [1:0] chain_len_i;
  logic [7:0] cfg_o;
  logic [5:0] swallow_o;
  logic [11:0] main_o;
  logic [12:0] ref_first_o, ref_second_o;
  logic [2:0] ref_func_o;
  logic sdata_o, ref_pending_o, phase_compare_frequency_o, vco_div_o, out_b_o, out_b_oe_n_o;
  int fail_count, total_checks;
  int gap;
  logic [7:0] far_byte;

  synth_serial_register_load u_synth_serial_register_load (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .sclk_i(sclk_i),
    .sdata_i(sdata_i),
    .load_strobe_n_i(load_strobe_n_i),
    .chain_en_i(chain_en_i),
    .chain_len_i(chain_len_i),
    .sdata_o(sdata_o),
    .reference_input_i(reference_input_i),
    .vco_i(vco_i),
    .cfg_o(cfg_o),
    .swallow_o(swallow_o),
    .main_o(main_o),
    .ref_first_o(ref_first_o),
    .ref_second_o(ref_second_o),
    .ref_func_o(ref_func_o),
    .ref_pending_o(ref_pending_o),
    .phase_compare_frequency_o(phase_compare_frequency_o),
    .vco_div_o(vco_div_o),
    .out_b_o(out_b_o),
    .out_b_oe_n_o(out_b_oe_n_o)
  );
  serial_host_model u_serial_host_model (.sys_clk_i(sys_clk_i), .sclk_o(sclk_i), .sdata_o(sdata_i),
    .load_strobe_n_o(load_strobe_n_i));

  // Clock and counter inputs
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always begin
    repeat (3) @(posedge sys_clk_i);
    #1 reference_input_i = ~reference_input_i;
    vco_i = ~vco_i;
  end

  // Second device of a cascade: takes the data out on each serial clock
  always @(posedge sclk_i) begin
    far_byte <= {far_byte[6:0], sdata_o};
  end

  // Cycles from one divided pulse to the next, starting at the next pulse
  task automatic pulse_gap(input logic use_vco, output int cycles);
    cycles = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
    end while (!(use_vco ? vco_div_o : phase_compare_frequency_o));
    do begin
      @(posedge sys_clk_i);
      #1;
      cycles++;
    end while (!(use_vco ? vco_div_o : phase_compare_frequency_o));
  endtask

  // Compare and count
  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Byte load and output B enable
  task automatic cfg_case(input logic [7:0] v);
    u_serial_host_model.send(24'(v), 8);
    check("cfg", 24'(v), 24'(cfg_o));
    check("oe_n", 24'(v[0]), 24'(out_b_oe_n_o));
    check("out_b", 24'h0, 24'(out_b_o));
  endtask

  // Main sequence
  initial begin
    {rstn_i, chain_en_i, chain_len_i, reference_input_i, vco_i} = 6'h00;
    fail_count = 0;
    total_checks = 0;
    repeat (12) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 check("oe_n", 24'h0, 24'(out_b_oe_n_o));
    cfg_case(8'h5b);
    cfg_case(8'h5a);
    u_serial_host_model.send(24'h00a003, 16);
    check("func", 24'h5, 24'(ref_func_o));
    check("first", 24'h0003, 24'(ref_first_o));
    check("second", 24'h0, 24'(ref_second_o));
    check("pending", 24'h1, 24'(ref_pending_o));
    check("cfg", 24'h5a, 24'(cfg_o));
    u_serial_host_model.send(24'h0, 0);
    check("second", 24'h0003, 24'(ref_second_o));
    check("first", 24'h0003, 24'(ref_first_o));
    // Reference edge every 6 cycles, ratio 3
    pulse_gap(1'b0, gap);
    check("ref_gap", 24'h12, 24'(gap));
    u_serial_host_model.send(24'h002004, 16);
    check("second", 24'h0003, 24'(ref_second_o));
    u_serial_host_model.send(24'hfc0045, 24);
    check("swallow", 24'h05, 24'(swallow_o));
    check("main", 24'h001, 24'(main_o));
    check("second", 24'h0004, 24'(ref_second_o));
    check("first", 24'h0004, 24'(ref_first_o));
    check("func", 24'h1, 24'(ref_func_o));
    check("cfg", 24'h5a, 24'(cfg_o));
    // New reference ratio 4 once the present cycle is done
    pulse_gap(1'b0, gap);
    check("ref_gap", 24'h18, 24'(gap));
    // Feedback ratio 1 * 64 + 5 = 69 edges of 6 cycles
    pulse_gap(1'b1, gap);
    check("vco_gap", 24'h19e, 24'(gap));
    u_serial_host_model.send(24'h0, 0);
    check("pending", 24'h0, 24'(ref_pending_o));
    check("swallow", 24'h05, 24'(swallow_o));
    // Cascade of two byte loads: first byte passes to the second device
    chain_en_i = 1'b1;
    u_serial_host_model.send(24'h00c3bc, 16);
    check("cfg", 24'hbc, 24'(cfg_o));
    check("far_byte", 24'hc3, 24'(far_byte));
    check("sdata_out", 24'h1, 24'(sdata_o));
    chain_en_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 check("sdata_out", 24'h0, 24'(sdata_o));
    close_out;
  end

  // Watchdog
  initial begin
    repeat (6000) @(posedge sys_clk_i);
    fail_count++;
    close_out;
  end
endmodule
`default_nettype wire
